/* cts_pkg.sv */
// cts_pkg: constants shared by the card cycle timing sequencer.
// assumes a 25 MHz pclk; card timing units are counted in pclk periods.
`default_nettype none
package cts_pkg;
   // register indices; byte address is four times the index
   localparam logic [5:0] CTS_IDX_SETUP0 = 6'h3a;
   localparam logic [5:0] CTS_IDX_CMD0 = 6'h3b;
   localparam logic [5:0] CTS_IDX_RECOV0 = 6'h3c;
   localparam logic [5:0] CTS_IDX_SETUP1 = 6'h3d;
   localparam logic [5:0] CTS_IDX_CMD1 = 6'h3e;
   localparam logic [5:0] CTS_IDX_RECOV1 = 6'h3f;
   localparam logic [5:0] CTS_IDX_STATUS = 6'h30;
   localparam int CTS_NUM_TIM = 6;
   // reset values, set 1 mirrors set 0
   localparam logic [7:0] CTS_RST_SETUP = 8'h01;
   localparam logic [7:0] CTS_RST_CMD = 8'h05;
   localparam logic [7:0] CTS_RST_RECOV = 8'h00;
   // timing register fields
   localparam int CTS_PRES_LSB = 6;
   localparam int CTS_MULT_W = 6;
   localparam logic [12:0] CTS_PRES_F0 = 13'h0001;
   localparam logic [12:0] CTS_PRES_F1 = 13'h0010;
   localparam logic [12:0] CTS_PRES_F2 = 13'h0100;
   localparam logic [12:0] CTS_PRES_F3 = 13'h1000;
   // status register bits
   localparam int CTS_ST_BUSY = 0;
   localparam int CTS_ST_IS16 = 1;
   localparam int CTS_ST_SET = 2;
   // timing
   localparam int CTS_CLK_NS = 40;
   localparam int CTS_CYC_PER_UNIT = 2;
   localparam int CTS_IOIS_UNITS = 3;
   localparam int CTS_IOIS_MARGIN_NS = 20;
   localparam int CTS_IOIS_WIN_CYC = CTS_IOIS_UNITS * CTS_CYC_PER_UNIT
      + (CTS_IOIS_MARGIN_NS + CTS_CLK_NS - 1) / CTS_CLK_NS;
   localparam int CTS_CE_SWITCH_NS = 20;
   localparam int CTS_CE_SWITCH_CYC = (CTS_CE_SWITCH_NS / CTS_CLK_NS < 1) ? 1
      : CTS_CE_SWITCH_NS / CTS_CLK_NS;
   localparam int CTS_WAIT_HOLD_UNITS = 2;
   localparam int CTS_WAIT_HOLD_CYC = CTS_WAIT_HOLD_UNITS * CTS_CYC_PER_UNIT;
   localparam int CTS_CNT_W = 20;
   typedef enum logic [1:0] {CTS_IDLE, CTS_SETUP, CTS_CMD, CTS_RECOV} cts_state_type;
endpackage : cts_pkg
`default_nettype wire

/* cts_sequencer.sv */
// cts_sequencer: phase timing of card accesses with apb timing registers.
// assumes the host path holds its request until req_ready, and apb without wait.
// Summary of operation
// R1 - setup phase lasts S units before strobe
// R2 - command strobe lasts C units
// R3 - address and data held R units
// R4 - phases run address, setup, command, recovery
// R5 - card drives iois16 within three units
// R6 - odd 8-bit io byte swaps card enables
// R7 - other byte accesses are normal byte cycles
// R8 - one card timing unit is two pclks
// R9 - late iois16 ignored, high enable stays off
// R10 - wait stretches strobe, two units after release
// R11 - each access picks one of two timer sets
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module cts_sequencer (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // host access path
   input wire logic req_valid,
   output logic req_ready,
   input wire logic req_write,
   input wire logic req_io,
   input wire logic req_word,
   input wire logic req_odd,
   input wire logic req_timer_set,
   input wire logic [25:0] req_addr,
   input wire logic [15:0] req_wdata,
   output logic rsp_done,
   output logic [15:0] rsp_rdata,
   // card socket
   output logic [25:0] card_addr,
   output logic card_reg_n,
   output logic card_ce1_n,
   output logic card_ce2_n,
   output logic card_oe_n,
   output logic card_we_n,
   output logic card_iord_n,
   output logic card_iowr_n,
   output logic [15:0] card_data_out,
   output logic card_data_oe,
   input wire logic [15:0] card_data_in,
   input wire logic card_wait_n,
   input wire logic card_iois16_n
);
   import cts_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // helpers
   // phase length in pclks: two per unit, unit count pres * mult + 1
   function automatic logic [CTS_CNT_W-1:0] cts_phase_cyc(input logic [7:0] tim);
      logic [12:0] pres;
      logic [CTS_CNT_W-1:0] units;
      pres = CTS_PRES_F0;
      case (tim[7:CTS_PRES_LSB])
         2'h0: pres = CTS_PRES_F0;
         2'h1: pres = CTS_PRES_F1;
         2'h2: pres = CTS_PRES_F2;
         default: pres = CTS_PRES_F3;
      endcase
      units = CTS_CNT_W'(pres * tim[CTS_MULT_W-1:0]) + CTS_CNT_W'(1);
      return CTS_CNT_W'(units * CTS_CYC_PER_UNIT); // R8
   endfunction : cts_phase_cyc

   ////////////////////////////////////////////////////////////////////////
   // apb register file
   logic [7:0] tim_q [CTS_NUM_TIM];
   cts_state_type state_q;
   logic set_q;
   logic is16_q;
   wire [5:0] idx = paddr[7:2];
   wire tim_hit = (idx >= CTS_IDX_SETUP0) && (idx <= CTS_IDX_RECOV1);
   wire st_hit = (idx == CTS_IDX_STATUS);
   wire [2:0] tim_sel = 3'(idx - CTS_IDX_SETUP0);
   wire apb_acc = psel && penable;
   wire apb_wr = apb_acc && pwrite && tim_hit;
   wire [31:0] st_word = {29'h0, set_q, is16_q, state_q != CTS_IDLE};

   assign pready = 1'b1;
   assign pslverr = apb_acc && !tim_hit && !st_hit;
   assign prdata = tim_hit ? {24'h0, tim_q[tim_sel]} : (st_hit ? st_word : 32'h0);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < CTS_NUM_TIM; i++) begin
            tim_q[i] <= (i % 3 == 0) ? CTS_RST_SETUP
               : ((i % 3 == 1) ? CTS_RST_CMD : CTS_RST_RECOV);
         end
      end else if (apb_wr) begin
         tim_q[tim_sel] <= pwdata[7:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // phase sequencer
   // timer set latched per access; its registers are read live, so a mid-cycle write changes later phases
   logic [CTS_CNT_W-1:0] cnt_q, cnt_d;
   cts_state_type state_d;
   logic [3:0] win_q;
   logic wr_q, io_q, word_q, odd_q;
   logic [15:0] wdata_q;
   wire [2:0] base = set_q ? 3'h3 : 3'h0; // R11
   wire [CTS_CNT_W-1:0] cyc_setup = cts_phase_cyc(tim_q[base]); // R1
   wire [CTS_CNT_W-1:0] cyc_cmd = cts_phase_cyc(tim_q[base + 3'h1]); // R2
   wire [CTS_CNT_W-1:0] cyc_recov = cts_phase_cyc(tim_q[base + 3'h2]); // R3
   wire last = (cnt_q == CTS_CNT_W'(1));
   wire wait_ext = (state_q == CTS_CMD) && !card_wait_n;
   wire start = req_valid && (state_q == CTS_IDLE);
   // odd io byte from a 16-bit host may fall back to an 8-bit card
   wire odd_io = io_q && !word_q && odd_q;
   wire narrow = odd_io && !is16_q; // R6
   wire win_open = (win_q != 4'h0);

   assign req_ready = (state_q == CTS_IDLE);

   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q - CTS_CNT_W'(1);
      case (state_q)
         CTS_IDLE: begin
            cnt_d = cyc_setup;
            if (req_valid) begin
               state_d = CTS_SETUP;
            end
         end
         CTS_SETUP: begin
            if (last) begin
               state_d = CTS_CMD; // R4
               cnt_d = cyc_cmd;
            end
         end
         CTS_CMD: begin
            if (wait_ext && cnt_q <= CTS_CNT_W'(CTS_WAIT_HOLD_CYC)) begin
               cnt_d = CTS_CNT_W'(CTS_WAIT_HOLD_CYC); // R10
            end else if (last) begin
               state_d = CTS_RECOV; // R4
               cnt_d = cyc_recov;
            end
         end
         CTS_RECOV: begin
            if (last) begin
               state_d = CTS_IDLE;
            end
         end
         default: begin
            state_d = CTS_IDLE;
         end
      endcase
   end

   // setup count is loaded at start from req_timer_set, as set_q latches on the same edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= CTS_IDLE;
         cnt_q <= '0;
         set_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q <= start ? cts_phase_cyc(tim_q[req_timer_set ? 3'h3 : 3'h0]) : cnt_d;
         if (start) begin
            set_q <= req_timer_set; // R11
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_q <= 1'b0;
         io_q <= 1'b0;
         word_q <= 1'b0;
         odd_q <= 1'b0;
         wdata_q <= 16'h0;
         card_addr <= 26'h0;
         card_reg_n <= 1'b1;
      end else if (start) begin
         wr_q <= req_write;
         io_q <= req_io;
         word_q <= req_word;
         odd_q <= req_odd;
         wdata_q <= req_wdata;
         card_addr <= req_addr; // R4
         card_reg_n <= !req_io;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // iois16 sampling window
   // the card must settle within the window; later changes are not looked at
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         win_q <= 4'h0;
         is16_q <= 1'b0;
      end else if (start) begin
         win_q <= 4'(CTS_IOIS_WIN_CYC); // R5
         is16_q <= 1'b0;
      end else if (win_open && state_q != CTS_IDLE) begin
         win_q <= win_q - 4'h1;
         is16_q <= !card_iois16_n; // R9
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // card enables, strobes, data
   wire active = (state_q != CTS_IDLE);
   wire strobe = (state_q == CTS_CMD);
   // enables follow is16_q one pclk after the sample, inside CTS_CE_SWITCH_CYC
   wire ce1_on = active && (word_q || !odd_q || narrow); // R6 R7
   wire ce2_on = active && (word_q || (odd_q && !narrow)); // R7 R9
   wire [15:0] dout = narrow ? {8'h0, wdata_q[15:8]} : wdata_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         card_ce1_n <= 1'b1;
         card_ce2_n <= 1'b1;
         card_oe_n <= 1'b1;
         card_we_n <= 1'b1;
         card_iord_n <= 1'b1;
         card_iowr_n <= 1'b1;
         card_data_out <= 16'h0;
         card_data_oe <= 1'b0;
      end else begin
         card_ce1_n <= !ce1_on;
         card_ce2_n <= !ce2_on;
         card_oe_n <= !(state_d == CTS_CMD && active && !io_q && !wr_q); // R2
         card_we_n <= !(state_d == CTS_CMD && active && !io_q && wr_q);
         card_iord_n <= !(state_d == CTS_CMD && active && io_q && !wr_q);
         card_iowr_n <= !(state_d == CTS_CMD && active && io_q && wr_q);
         card_data_out <= dout; // R3
         card_data_oe <= active && wr_q && (state_d != CTS_IDLE);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // host answer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rsp_done <= 1'b0;
         rsp_rdata <= 16'h0;
      end else begin
         rsp_done <= (state_q == CTS_RECOV) && last;
         if (strobe && last && !wait_ext && !wr_q) begin
            rsp_rdata <= narrow ? {card_data_in[7:0], 8'h0} : card_data_in;
         end
      end
   end
endmodule : cts_sequencer
`default_nettype wire

/* cts_end.sv */
// cts_end: intentionally empty; all logic lives in cts_sequencer.
// assumes nothing.

/* cts_card_model.sv */
// cts_card_model: behavioural card on the socket.
// assumes strobes and address registered on pclk.
`timescale 1ns/1ns
`default_nettype none
module cts_card_model (
   // socket
   input wire logic pclk,
   input wire logic [25:0] card_addr,
   input wire logic card_oe_n,
   input wire logic card_iord_n,
   output logic [15:0] card_data_in = 16'h0000,
   output logic card_wait_n = 1'b1,
   output logic card_iois16_n = 1'b1,
   // test controls
   input wire logic wide_io,
   input wire logic [3:0] wait_len
);
   logic [3:0] cnt_q = 4'h0;
   wire rd = !(card_oe_n && card_iord_n);
   // idle bus toggles so a stale value never passes
   always @(posedge pclk) begin
      card_iois16_n <= !wide_io;
      card_data_in <= rd ? card_addr[15:0] ^ 16'h5a3c : ~card_data_in;
      cnt_q <= !rd ? 4'h0 : cnt_q < wait_len ? cnt_q + 4'h1 : cnt_q;
      card_wait_n <= !(rd && cnt_q < wait_len);
   end
endmodule : cts_card_model
`default_nettype wire

/* cts_sequencer_checker.sv */
// cts_sequencer_checker: port properties of the sequencer.
// assumes binding to cts_sequencer.
`timescale 1ns/1ns
`default_nettype none
module cts_sequencer_checker (
   input wire logic pclk, presetn, psel, penable, pready, pslverr,
   input wire logic [7:0] paddr,
   input wire logic req_valid, req_ready, rsp_done, card_wait_n,
   input wire logic [25:0] req_addr, card_addr,
   input wire logic card_ce1_n, card_ce2_n, card_oe_n, card_we_n, card_iord_n, card_iowr_n
);
   wire take = req_valid && req_ready;
   wire strb = card_oe_n && card_we_n && card_iord_n && card_iowr_n;
   wire ce_on = !(card_ce1_n && card_ce2_n);
   // decode ignores the two low address bits, as the register file does
   wire mapped = (paddr[7:2] >= 6'h3a) || (paddr[7:2] == 6'h30);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   AST_SETUP: assert property (take |=> strb && card_addr == $past(req_addr))
      else $error("bad strobe or address after accept");
   AST_CMD: assert property ($fell(strb) |=> !strb)
      else $error("strobe shorter than one unit");
   AST_RECOV: assert property ($rose(strb) |=> ce_on && $stable(card_addr))
      else $error("address dropped in recovery");
   AST_ORDER: assert property ($fell(strb) |-> ce_on && !req_ready)
      else $error("strobe without enable");
   AST_DONE: assert property (rsp_done |-> strb && req_ready && ce_on ##1 !ce_on)
      else $error("done while card active");
   AST_BUSY: assert property (take |=> !req_ready [*2])
      else $error("ready during setup");
   AST_WAIT: assert property ($rose(strb) |-> $past(card_wait_n) && $past(card_wait_n, 4))
      else $error("strobe released early after wait");
   AST_APB: assert property (psel && penable |-> pready && pslverr == !mapped)
      else $error("bad apb answer");
   cover property (take);
   cover property (!card_wait_n && !strb);
   cover property (psel && penable && pslverr);
endmodule : cts_sequencer_checker
bind cts_sequencer cts_sequencer_checker u_chk (.*);
`default_nettype wire

/* cts_sequencer_tb_top.sv */
// cts_sequencer_tb_top: directed apb and host tests.
// assumes the card model on the socket and the bound checker.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, a) begin checks++; if ((a) !== (e)) begin bad_count++; \
   $display("ERROR %s expected %h seen %h", nm, e, a); end end
module card_cycle_timing_sequencer_tb_top;
   import cts_pkg::*;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic req_valid = 1'b0, req_write = 1'b0, req_io = 1'b0, req_word = 1'b0;
   logic req_odd = 1'b0, req_timer_set = 1'b0, wide_io = 1'b0;
   logic [25:0] req_addr = 26'h0, card_addr;
   logic [15:0] req_wdata = 16'h0, rsp_rdata, card_data_out, card_data_in;
   logic pready, pslverr, req_ready, rsp_done, card_reg_n, card_ce1_n, card_ce2_n;
   logic card_oe_n, card_we_n, card_iord_n, card_iowr_n, card_data_oe, card_wait_n;
   logic card_iois16_n;
   logic [3:0] wait_len = 4'h0;
   logic [1:0] ce_q = 2'b00;
   logic rg_q = 1'b1;
   logic [15:0] wd_q = 16'h0;
   int bad_count = 0, checks = 0, cyc = 0;
   cts_sequencer u_dut (.*);
   cts_card_model u_card (.*);
   initial forever #20 pclk = ~pclk;
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 4000) begin
         bad_count++;
         summarize();
      end
   end
   // last enable pair seen under the io read strobe, after the sizing window
   always @(posedge pclk) if (!card_iord_n) {rg_q, ce_q} <= {card_reg_n, card_ce2_n, card_ce1_n};
   // last write data seen under the memory write strobe
   always @(posedge pclk) if (!card_we_n && card_data_oe) wd_q <= card_data_out;
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata; e = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   // k = {write, io, word, odd, timer set}; n counts edges to the done pulse
   task automatic host(input logic [4:0] k, input logic [25:0] a, output logic [15:0] q,
      output int n);
      {req_write, req_io, req_word, req_odd, req_timer_set} <= k;
      req_addr <= a; req_wdata <= a[15:0]; req_valid <= 1'b1;
      do @(posedge pclk); while (req_ready !== 1'b1);
      req_valid <= 1'b0;
      n = 0;
      do begin @(posedge pclk); n++; end while (rsp_done !== 1'b1);
      q = rsp_rdata;
      @(posedge pclk);
   endtask : host
   task automatic summarize();
      $display("checks %0d errors %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : summarize
   initial begin
      logic [31:0] q;
      logic e;
      logic [15:0] d;
      logic [15:0] x;
      int n;
      logic [7:0] t1 [3];
      t1 = '{8'h03, 8'h41, 8'h02};
      x = 16'h0301 ^ 16'h5a3c;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (int i = 0; i < 6; i++) begin
         apb(1'b0, 8'he8 + 8'(4 * i), 32'h0, q, e);
         `CHK("timer", (i % 3 == 0) ? 32'h1 : (i % 3 == 1) ? 32'h5 : 32'h0, q)
      end
      apb(1'b1, 8'h10, 32'hff, q, e);
      `CHK("unmapped", 1'b1, e)
      host(5'b00100, 26'h0123456, d, n);
      `CHK("cycles", 19, n)
      `CHK("rdata", 16'h3456 ^ 16'h5a3c, d)
      for (int i = 0; i < 3; i++) begin
         apb(1'b1, 8'hf4 + 8'(4 * i), {24'h0, t1[i]}, q, e);
         apb(1'b0, 8'hf4 + 8'(4 * i), 32'h0, q, e);
         `CHK("set1", {24'h0, t1[i]}, q)
      end
      host(5'b10101, 26'h0000200, d, n);
      `CHK("cycles set1", 49, n)
      `CHK("write data", 16'h0200, wd_q)
      apb(1'b0, 8'hc0, 32'h0, q, e);
      `CHK("status", 32'h1 << CTS_ST_SET, q)
      for (int w = 0; w < 2; w++) begin
         wide_io <= w[0];
         repeat (2) @(posedge pclk);
         host(5'b01010, 26'h0000301, d, n);
         `CHK("odd ce", w ? 2'b01 : 2'b10, ce_q)
         `CHK("odd data", w ? x[15:8] : x[7:0], d[15:8])
         `CHK("odd cycles", 19, n)
         `CHK("io reg", 1'b0, rg_q)
      end
      wait_len <= 4'hc;
      host(5'b00100, 26'h0000044, d, n);
      `CHK("wait stretch", 1'b1, n > 20)
      `CHK("wait data", 16'h0044 ^ 16'h5a3c, d)
      summarize();
   end
endmodule : card_cycle_timing_sequencer_tb_top
`default_nettype wire
